// ### shared/adc_out_pkg.sv
// Purpose: Shared constants for the quad converter output block
// Assumes: Left-aligned 16-bit words, two clocks per serial bit
// Notes: Mode register map is a small two-register layout
package adc_out_pkg;
  localparam int NUM_CH = 4;
  localparam int RES_BITS = 12;
  localparam int WORD_BITS = 16;
  localparam int PIPE_DEPTH = 6;
  localparam int SPI_BITS = 16;
  localparam int SYNC_PINS = 8;
  // Padding bits follow the result
  localparam logic [1:0] PAD_BITS = 2'h0;
  // Mode register addresses and reset values
  localparam logic [6:0] ADDR_OUTPUT = 7'h01;
  localparam logic [6:0] ADDR_FORMAT = 7'h02;
  localparam logic [7:0] OUTPUT_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  // Field positions
  localparam int OUT_PWR_DOWN_BIT = 0;
  localparam int OUT_DRIVE_HALF_BIT = 1;
  localparam int OUT_TERM_BIT = 2;
  localparam int FMT_ONE_LANE_BIT = 0;
  localparam int FMT_WIDTH_LSB = 1;
  // Frame lengths per serialization width
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_14 = 5'h0E;
  localparam logic [4:0] LEN_12 = 5'h0C;
  typedef enum logic [1:0] {
    WIDTH_16 = 2'b00,
    WIDTH_14 = 2'b01,
    WIDTH_12 = 2'b10
  } width_e;
  typedef enum logic {
    SER_IDLE = 1'b0,
    SER_SEND = 1'b1
  } ser_state_e;
endpackage : adc_out_pkg

// ### verilog/lane_pair_ser.sv
// Purpose: Two-lane shifter for one converter channel
// Assumes: Load and shift come from the frame timer
// Notes: Lane B idles low and disabled in one-lane mode
`timescale 1ns/1ps
module lane_pair_ser (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic i_shift,
  input wire logic i_stop,
  input wire logic i_two_lane,
  input wire logic i_on,
  input wire logic [adc_out_pkg::WORD_BITS-1:0] i_word,
  output logic o_lane_a,
  output logic o_lane_b,
  output logic o_en_a,
  output logic o_en_b
);
  import adc_out_pkg::*;
  logic [WORD_BITS-1:0] sh_reg;
  logic [WORD_BITS-1:0] src;
  // Word source: fresh word or remaining bits
  assign src = i_load ? i_word : sh_reg;
  // Shift register and lane bits, MSB first on both lanes
  always_ff @(posedge i_clk) begin
    if (i_reset || i_stop) begin
      sh_reg <= '0;
      o_lane_a <= 1'b0;
      o_lane_b <= 1'b0;
    end else if (i_load || i_shift) begin
      o_lane_a <= src[WORD_BITS-1];
      o_lane_b <= i_two_lane ? src[WORD_BITS-2] : 1'b0; // RQ4
      sh_reg <= i_two_lane ? {src[WORD_BITS-3:0], 2'b00} : {src[WORD_BITS-2:0], 1'b0};
    end
  end
  // Lane enables follow power and lane mode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_en_a <= 1'b0;
      o_en_b <= 1'b0;
    end else begin
      o_en_a <= i_on;
      o_en_b <= i_on && i_two_lane; // RQ4
    end
  end
endmodule : lane_pair_ser

// ### verilog/spi_mode_port.sv
// Purpose: Serial write and readback on the serial clock
// Assumes: Frame is R/W bit, 7-bit address, 8-bit data
// Notes: Readback bytes are quasi-static, sampled once per frame
`timescale 1ns/1ps
module spi_mode_port (
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic [7:0] i_rd_output,
  input wire logic [7:0] i_rd_format,
  output logic [adc_out_pkg::SPI_BITS-2:0] o_wr_word,
  output logic o_wr_toggle,
  output logic o_sdo_oe_n
);
  import adc_out_pkg::*;
  logic [3:0] cnt_reg;
  logic [SPI_BITS-2:0] sh_reg;
  logic [7:0] rd_reg;
  logic rd_mode_reg;
  logic [6:0] addr;
  // Address completes on the eighth rising edge
  assign addr = {sh_reg[5:0], i_sdi};
  // Bit counter cleared whenever chip select is high
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt_reg <= 4'h0; // RQ19
    end else begin
      cnt_reg <= cnt_reg + 4'h1; // RQ6
    end
  end
  // Capture SDI on rising SCK, publish finished writes
  always_ff @(posedge i_sck) begin
    if (!i_cs_n) begin
      sh_reg <= {sh_reg[SPI_BITS-3:0], i_sdi}; // RQ7
      if (cnt_reg == 4'h7) begin
        rd_mode_reg <= sh_reg[6];
        rd_reg <= (addr == ADDR_OUTPUT) ? i_rd_output :
                  (addr == ADDR_FORMAT) ? i_rd_format : 8'h00;
      end
      // Write flag drops at frame start, rises on a full write
      if (cnt_reg == 4'h0) begin
        o_wr_toggle <= 1'b0;
      end
      if (cnt_reg == 4'hF && !sh_reg[14]) begin
        o_wr_word <= {sh_reg[13:0], i_sdi};
        o_wr_toggle <= 1'b1;
      end
    end
  end
  // Open-drain readback changes on falling SCK
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_sdo_oe_n <= 1'b1;
    end else begin
      o_sdo_oe_n <= !(rd_mode_reg && cnt_reg[3] && !rd_reg[~cnt_reg[2:0]]); // RQ8
    end
  end
  chk_cs_hold: assert property (@(posedge i_sck) disable iff (i_cs_n) // RQ6
    !i_cs_n |=> cnt_reg == $past(cnt_reg) + 4'h1)
    else $error("bit counter did not advance");
  chk_sdi_capture: assert property (@(posedge i_sck) disable iff (i_cs_n) // RQ7
    !i_cs_n |=> sh_reg[0] == $past(i_sdi))
    else $error("SDI not captured on rising SCK");
endmodule : spi_mode_port

// ### verilog/quad_adc_out.sv
// Purpose: Serial output framing and mode pins of a quad converter
// Assumes: Results arrive on I_CLK; encode and config pins are async
// Notes: One serial bit lasts two I_CLK cycles; encode must be slow
//
// Overview of operation
// (RQ1) Padding bits are always driven as zero
// (RQ2) Two padding bits follow twelve result bits
// (RQ3) Two-lane 14-bit: frame start toggles per word
// (RQ4) One-lane mode disables every second lane
// (RQ5) Conversion starts on rising true encode
// (RQ6) Serial shifting only while chip select low
// (RQ7) SDI captured on rising serial clock
// (RQ8) Readback driven open-drain on SDO
// (RQ9) Select low: pins form serial port
// (RQ10) Select high: pins are static levels
// (RQ11) Parallel: chip select picks lane mode
// (RQ12) Parallel: serial clock picks drive current
// (RQ13) Parallel: SDI powers down the device
// (RQ14) Parallel: SDO enables output termination
// (RQ15) Data changes midway between clock edges
// (RQ16) Frame start marks each new word
// (RQ17) Widths of 16, 14 and 12 bits
// (RQ18) Output lags sample by six encodes
// (RQ19) Chip select high leaves registers unchanged
// (RQ20) Same bit order on all channels
`timescale 1ns/1ps
module quad_adc_out (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic i_ENCODE_IN_TRUE,
  input wire logic i_ENCODE_IN_COMP,
  input wire logic i_PROGRAM_MODE_SELECT,
  input wire logic i_CS_N,
  input wire logic i_SCK,
  input wire logic i_SDI,
  input wire logic i_SDO_IN,
  input wire logic [adc_out_pkg::RES_BITS-1:0] i_RESULT_CH0,
  input wire logic [adc_out_pkg::RES_BITS-1:0] i_RESULT_CH1,
  input wire logic [adc_out_pkg::RES_BITS-1:0] i_RESULT_CH2,
  input wire logic [adc_out_pkg::RES_BITS-1:0] i_RESULT_CH3,
  output logic [adc_out_pkg::NUM_CH-1:0] o_LANE_A,
  output logic [adc_out_pkg::NUM_CH-1:0] o_LANE_B,
  output logic [adc_out_pkg::NUM_CH-1:0] o_LANE_A_ENABLE,
  output logic [adc_out_pkg::NUM_CH-1:0] o_LANE_B_ENABLE,
  output logic o_DATA_CLOCK_OUT,
  output logic o_FRAME_START_OUT,
  output logic o_SDO_OUT,
  output logic o_SDO_OE_N,
  output logic o_POWER_DOWN,
  output logic o_DRIVE_HALF,
  output logic o_TERMINATION_ENABLE
);
  import adc_out_pkg::*;

  // Pin synchronisers, three stages each
  logic [SYNC_PINS-1:0] pin_raw;
  logic [SYNC_PINS-1:0] s1_reg;
  logic [SYNC_PINS-1:0] s2_reg;
  logic [SYNC_PINS-1:0] s3_reg;
  logic [SYNC_PINS-1:0] filt_reg;
  logic wr_toggle;
  logic [SPI_BITS-2:0] wr_word;

  // Filtered pin levels
  logic par_mode;
  logic cs_lvl;
  logic sck_lvl;
  logic sdi_lvl;
  logic sdo_lvl;
  logic enc_lvl;
  logic wr_tog_lvl;

  // Mode state
  logic [7:0] output_reg;
  logic [7:0] format_reg;
  logic wr_seen_reg;
  logic one_lane_reg;
  logic [1:0] width_reg;
  logic power_down_reg;

  // Encode and pipeline
  logic enc_prev_reg;
  logic enc_rise;
  logic [RES_BITS-1:0] pipe_reg [NUM_CH][PIPE_DEPTH+1];
  logic [RES_BITS-1:0] res_in [NUM_CH];

  // Frame timing
  ser_state_e state_reg;
  logic pending_reg;
  logic phase_reg;
  logic [4:0] bit_cnt_reg;
  logic [4:0] frame_len;
  logic [4:0] lane_len;
  logic halved;
  logic load;
  logic step;
  logic stop;
  logic [WORD_BITS-1:0] word [NUM_CH];

  assign pin_raw = {wr_toggle, i_ENCODE_IN_COMP, i_ENCODE_IN_TRUE, i_SDO_IN,
                    i_SDI, i_SCK, i_CS_N, i_PROGRAM_MODE_SELECT};
  assign par_mode = filt_reg[0];
  assign cs_lvl = filt_reg[1];
  assign sck_lvl = filt_reg[2];
  assign sdi_lvl = filt_reg[3];
  assign sdo_lvl = filt_reg[4];
  assign enc_lvl = filt_reg[5] & ~filt_reg[6];
  assign wr_tog_lvl = filt_reg[7];

  // Three-flop chain; a level counts once stages two and three agree
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    end
  end

  // Serial port on its own clock; chip select gates it
  spi_mode_port u_spi (
    .i_sck(i_SCK),
    .i_cs_n(i_CS_N | i_PROGRAM_MODE_SELECT), // RQ9
    .i_sdi(i_SDI),
    .i_rd_output(output_reg),
    .i_rd_format(format_reg),
    .o_wr_word(wr_word),
    .o_wr_toggle(wr_toggle),
    .o_sdo_oe_n(o_SDO_OE_N)
  );

  // Open-drain data is always low; only the enable moves
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      o_SDO_OUT <= 1'b0;
    end else begin
      o_SDO_OUT <= 1'b0;
    end
  end

  // Mode registers take writes when the write flag rises
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      output_reg <= OUTPUT_RESET;
      format_reg <= FORMAT_RESET;
      wr_seen_reg <= 1'b0;
    end else begin
      wr_seen_reg <= wr_tog_lvl;
      if (wr_tog_lvl && !wr_seen_reg && !par_mode) begin // RQ9
        if (wr_word[14:8] == ADDR_OUTPUT) begin
          output_reg <= wr_word[7:0];
        end
        if (wr_word[14:8] == ADDR_FORMAT) begin
          format_reg <= wr_word[7:0];
        end
      end
    end
  end

  // Operating modes: pin levels in parallel mode (width fixed at 16), registers otherwise
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      one_lane_reg <= 1'b0;
      width_reg <= WIDTH_16;
      power_down_reg <= 1'b0;
      o_POWER_DOWN <= 1'b0;
      o_DRIVE_HALF <= 1'b0;
      o_TERMINATION_ENABLE <= 1'b0;
    end else if (par_mode) begin // RQ10
      one_lane_reg <= cs_lvl; // RQ11
      width_reg <= WIDTH_16;
      o_DRIVE_HALF <= sck_lvl; // RQ12
      power_down_reg <= sdi_lvl; // RQ13
      o_POWER_DOWN <= sdi_lvl; // RQ13
      o_TERMINATION_ENABLE <= sdo_lvl; // RQ14
    end else begin // RQ9
      one_lane_reg <= format_reg[FMT_ONE_LANE_BIT];
      width_reg <= format_reg[FMT_WIDTH_LSB +: 2];
      o_DRIVE_HALF <= output_reg[OUT_DRIVE_HALF_BIT];
      power_down_reg <= output_reg[OUT_PWR_DOWN_BIT];
      o_POWER_DOWN <= output_reg[OUT_PWR_DOWN_BIT];
      o_TERMINATION_ENABLE <= output_reg[OUT_TERM_BIT];
    end
  end

  // Frame length per width; unknown code falls back to 16
  always_comb begin
    unique case (width_reg)
      WIDTH_14: frame_len = LEN_14;
      WIDTH_12: frame_len = LEN_12;
      default: frame_len = LEN_16;
    endcase
  end
  assign lane_len = one_lane_reg ? frame_len : {1'b0, frame_len[4:1]}; // RQ17
  assign halved = !one_lane_reg && width_reg == WIDTH_14; // RQ3

  // Encode edge detection
  assign enc_rise = enc_lvl && !enc_prev_reg; // RQ5
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      enc_prev_reg <= 1'b0;
    end else begin
      enc_prev_reg <= enc_lvl;
    end
  end

  // Sample pipeline; the last stage is six encodes old
  assign res_in[0] = i_RESULT_CH0;
  assign res_in[1] = i_RESULT_CH1;
  assign res_in[2] = i_RESULT_CH2;
  assign res_in[3] = i_RESULT_CH3;
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int s = 0; s <= PIPE_DEPTH; s++) begin
          pipe_reg[c][s] <= '0;
        end
      end
    end else if (enc_rise) begin // RQ5
      for (int c = 0; c < NUM_CH; c++) begin
        pipe_reg[c][0] <= res_in[c];
        for (int s = 1; s <= PIPE_DEPTH; s++) begin
          pipe_reg[c][s] <= pipe_reg[c][s-1]; // RQ18
        end
      end
    end
  end

  // Word layout: result MSB first, two pad bits, then zero fill
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      word[c] = {pipe_reg[c][PIPE_DEPTH], PAD_BITS, 2'h0}; // RQ1 RQ2 RQ20
    end
  end

  // Bit phase: data moves on phase 1, clock out flips on phase 0
  assign load = pending_reg && phase_reg && !power_down_reg;
  assign step = phase_reg && state_reg == SER_SEND && !pending_reg &&
                bit_cnt_reg != lane_len;
  assign stop = power_down_reg ||
                (phase_reg && state_reg == SER_SEND && !pending_reg &&
                 bit_cnt_reg == lane_len);

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      phase_reg <= 1'b0;
      o_DATA_CLOCK_OUT <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (power_down_reg) begin
        o_DATA_CLOCK_OUT <= 1'b0;
      end else if (!phase_reg) begin
        o_DATA_CLOCK_OUT <= ~o_DATA_CLOCK_OUT; // RQ15
      end
    end
  end

  // Frame sequencer
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state_reg <= SER_IDLE;
      pending_reg <= 1'b0;
      bit_cnt_reg <= 5'h0;
    end else begin
      if (enc_rise && !power_down_reg) begin
        pending_reg <= 1'b1; // RQ5
      end else if (load || power_down_reg) begin
        pending_reg <= 1'b0;
      end
      if (load) begin
        state_reg <= SER_SEND;
        bit_cnt_reg <= 5'h1;
      end else if (stop) begin
        state_reg <= SER_IDLE;
        bit_cnt_reg <= 5'h0;
      end else if (step) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h1;
      end
    end
  end

  // Frame start: high for first half, or toggling per word when halved
  always_ff @(posedge I_CLK) begin
    if (I_RESET || power_down_reg) begin
      o_FRAME_START_OUT <= 1'b0;
    end else if (load) begin
      o_FRAME_START_OUT <= halved ? ~o_FRAME_START_OUT : 1'b1; // RQ3 RQ16
    end else if (step && !halved && bit_cnt_reg == {1'b0, lane_len[4:1]}) begin
      o_FRAME_START_OUT <= 1'b0; // RQ16
    end
  end

  // One shifter per channel, identical ordering
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    lane_pair_ser u_ser (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .i_load(load),
      .i_shift(step),
      .i_stop(stop),
      .i_two_lane(!one_lane_reg),
      .i_on(!power_down_reg),
      .i_word(word[c]),
      .o_lane_a(o_LANE_A[c]),
      .o_lane_b(o_LANE_B[c]),
      .o_en_a(o_LANE_A_ENABLE[c]),
      .o_en_b(o_LANE_B_ENABLE[c])
    );
  end

  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  chk_lane_b_off: assert property (one_lane_reg |=> o_LANE_B_ENABLE == '0) // RQ4
    else $error("second lane enabled in one-lane mode");
  chk_lane_b_low: assert property (one_lane_reg && $past(one_lane_reg) |-> o_LANE_B == '0) // RQ4
    else $error("second lane carries data in one-lane mode");
  chk_fr_start: assert property (load && !halved |=> o_FRAME_START_OUT) // RQ16
    else $error("frame start not high at word start");
  chk_fr_halved: assert property (load && halved |=> o_FRAME_START_OUT != $past(o_FRAME_START_OUT)) // RQ3
    else $error("frame start did not toggle in halved mode");
  chk_encode_load: assert property (enc_rise && !power_down_reg |-> ##[1:3] load) // RQ5
    else $error("encode edge did not start a word");
  chk_pad_zero: assert property (state_reg == SER_SEND && // RQ1
    bit_cnt_reg > (one_lane_reg ? LEN_12 : {1'b0, LEN_12[4:1]}) |->
    o_LANE_A == '0 && o_LANE_B == '0)
    else $error("padding bits not zero");
  chk_dco_mid: assert property (!power_down_reg && phase_reg |=> $stable(o_DATA_CLOCK_OUT)) // RQ15
    else $error("clock out moved with the data");
  chk_par_lane: assert property (par_mode |=> one_lane_reg == $past(cs_lvl)) // RQ11
    else $error("chip select level not steering lane mode");
  chk_par_power: assert property (par_mode |=> o_POWER_DOWN == $past(sdi_lvl)) // RQ13
    else $error("SDI level not steering power down");
  chk_par_term: assert property (par_mode |=> o_TERMINATION_ENABLE == $past(sdo_lvl)) // RQ14
    else $error("SDO level not steering termination");
  chk_par_drive: assert property (par_mode |=> o_DRIVE_HALF == $past(sck_lvl)) // RQ12
    else $error("SCK level not steering drive current");
  chk_pipe_age: assert property (enc_rise |=> pipe_reg[1][PIPE_DEPTH] == $past(pipe_reg[1][PIPE_DEPTH-1])) // RQ18
    else $error("pipeline stage skipped");
endmodule : quad_adc_out

// ### verification/cfg_host_model.sv
// Purpose: Configuration host model on the serial mode port
// Assumes: SCK period 12 ns, SCK stands still outside frames
// Notes: SDI is inverted once released so stale bits never pass
`timescale 1ns/1ps
module cfg_host_model (
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi,
  input wire logic i_sdo_line
);
  // Idle levels
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end

  // One 16-bit frame, MSB first; sel low keeps chip select high
  task automatic xfer(input logic [15:0] frame, input logic sel, output logic [7:0] rd);
    rd = 8'h00;
    o_cs_n = ~sel;
    #6;
    for (int i = 0; i < 16; i++) begin
      o_sdi = frame[15-i];
      #3 o_sck = 1'b1;
      if (i >= 8) begin
        rd[15-i] = i_sdo_line;
      end
      #6 o_sck = 1'b0;
      #3;
    end
    o_sdi = ~o_sdi;
    #6 o_cs_n = 1'b1;
    #12;
  endtask : xfer

  // Static levels for parallel mode
  task automatic set_static(input logic cs, input logic sck, input logic sdi);
    o_cs_n = cs;
    o_sck = sck;
    o_sdi = sdi;
  endtask : set_static
endmodule : cfg_host_model

// ### verification/testbench.sv
// Purpose: Self-checking bench for the quad converter output block
// Assumes: Encode period 50 cycles, results change only between encodes
// Notes: Driver queues expected words, lane monitor compares them
`timescale 1ns/1ps
module testbench;
  import adc_out_pkg::*;
  logic clk, rst, enc, par, sdo_lvl, sdo_line, cs_n, sck, sdi, data_clock_out, fr, sdo_out, sdo_oe_n;
  logic pwr_dn, drv_half, term_en;
  logic [NUM_CH-1:0] lane_a, lane_b, en_a, en_b;
  logic [RES_BITS-1:0] res [NUM_CH];
  logic [63:0] exp_q [$];
  logic [63:0] hist [$];
  int errors, total_checks, cycles, frames_seen, lane_len, two_lane, halved;
  int len_t [6] = '{16, 14, 12, 16, 12, 14};
  logic [2:0] fmt_t [6] = '{3'h1, 3'h3, 3'h5, 3'h0, 3'h4, 3'h2};

  // Open-drain readback line with pull-up
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;

  quad_adc_out quad_adc_out_i (
    .I_CLK(clk), .I_RESET(rst), .i_ENCODE_IN_TRUE(enc), .i_ENCODE_IN_COMP(~enc),
    .i_PROGRAM_MODE_SELECT(par), .i_CS_N(cs_n), .i_SCK(sck), .i_SDI(sdi),
    .i_SDO_IN(par ? sdo_lvl : sdo_line),
    .i_RESULT_CH0(res[0]), .i_RESULT_CH1(res[1]), .i_RESULT_CH2(res[2]),
    .i_RESULT_CH3(res[3]), .o_LANE_A(lane_a), .o_LANE_B(lane_b),
    .o_LANE_A_ENABLE(en_a), .o_LANE_B_ENABLE(en_b), .o_DATA_CLOCK_OUT(data_clock_out),
    .o_FRAME_START_OUT(fr), .o_SDO_OUT(sdo_out), .o_SDO_OE_N(sdo_oe_n),
    .o_POWER_DOWN(pwr_dn), .o_DRIVE_HALF(drv_half), .o_TERMINATION_ENABLE(term_en)
  );

  cfg_host_model cfg_host_model_i (
    .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi), .i_sdo_line(sdo_line)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle ceiling against a hung run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expd);
    total_checks++;
    if (seen !== expd) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, expd, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // One encode with fresh results; keep notes the word due six encodes later
  task automatic encode_one(input logic keep);
    for (int c = 0; c < NUM_CH; c++) begin
      res[c] = RES_BITS'($urandom);
    end
    if (keep) begin
      hist.push_back({res[3], 4'h0, res[2], 4'h0, res[1], 4'h0, res[0], 4'h0});
      if (hist.size() > PIPE_DEPTH) begin
        exp_q.push_back(hist.pop_front());
      end
    end
    @(negedge clk);
    enc = 1'b1;
    repeat (10) @(negedge clk);
    enc = 1'b0;
    repeat (39) @(negedge clk);
  endtask : encode_one

  // Ten encodes in one lane mode and width; every word due within the run must appear
  task automatic run_mode(input int len, input int two);
    lane_len = len;
    two_lane = two;
    halved = (two != 0 && len == 14);
    hist.delete();
    exp_q.delete();
    repeat (10) encode_one(1'b1);
    repeat (20) @(negedge clk);
    check("frames_left", 64'(exp_q.size()), 64'h0);
  endtask : run_mode

  // Lane monitor: one word per frame start, compared with the oldest note
  initial begin : monitor
    logic [63:0] got;
    logic [63:0] mask;
    logic fr_prev;
    logic dco_prev;
    int dco_bad;
    int b_bad;
    fr_prev = 1'b0;
    forever begin
      @(negedge clk);
      if (!rst && fr !== fr_prev && (fr === 1'b1 || halved != 0)) begin
        frames_seen++;
        got = '0;
        dco_bad = 0;
        b_bad = 0;
        dco_prev = ~data_clock_out;
        for (int k = 0; k < (two_lane != 0 ? lane_len / 2 : lane_len); k++) begin
          if (k > 0) repeat (2) @(negedge clk);
          dco_bad += int'(data_clock_out === dco_prev);
          dco_prev = data_clock_out;
          for (int c = 0; c < NUM_CH; c++) begin
            if (two_lane != 0) begin
              got[c*16+15-2*k] = lane_a[c];
              got[c*16+14-2*k] = lane_b[c];
              b_bad += int'(en_b[c] !== 1'b1);
            end else begin
              got[c*16+15-k] = lane_a[c];
              b_bad += int'(lane_b[c] !== 1'b0 || en_b[c] !== 1'b0);
            end
          end
        end
        mask = {4{16'hFFFF << (16 - lane_len)}};
        check("dco_alternates", 64'(dco_bad), 64'h0);
        check("lane_b_mode", 64'(b_bad), 64'h0);
        check("lane_a_on", 64'(en_a), 64'hF);
        if (exp_q.size() > 0) begin
          check("frame_bits", got & mask, exp_q.pop_front() & mask);
        end
      end
      fr_prev = fr;
    end
  end

  // Main sequence
  initial begin : main
    logic [7:0] rd;
    logic [3:0] r;
    int seen0;
    void'($urandom(29407));
    rst = 1'b1;
    enc = 1'b0;
    par = 1'b0;
    sdo_lvl = 1'b0;
    for (int c = 0; c < NUM_CH; c++) res[c] = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    check("mode_reset", 64'({pwr_dn, drv_half, term_en}), 64'h0);
    // Output register: every pattern written, seen at the pins, read back
    for (int v = 0; v < 8; v++) begin
      cfg_host_model_i.xfer({1'b0, ADDR_OUTPUT, 5'h00, 3'(v)}, 1'b1, rd);
      repeat (10) @(negedge clk);
      check("out_pins", 64'({term_en, drv_half, pwr_dn}), 64'(v));
      cfg_host_model_i.xfer({1'b1, ADDR_OUTPUT, 8'h00}, 1'b1, rd);
      check("out_readback", 64'(rd), 64'(v));
    end
    // Clocks with chip select high, then an unmapped read
    cfg_host_model_i.xfer({1'b0, ADDR_OUTPUT, 8'h00}, 1'b0, rd);
    repeat (10) @(negedge clk);
    check("cs_high_ignored", 64'({term_en, drv_half, pwr_dn}), 64'h7);
    cfg_host_model_i.xfer({1'b1, 7'h7F, 8'h00}, 1'b1, rd);
    check("unmapped_read", 64'(rd), 64'h0);
    cfg_host_model_i.xfer({1'b0, ADDR_OUTPUT, 8'h00}, 1'b1, rd);
    // Every lane mode and width; the halved frame mode runs last
    for (int m = 0; m < 6; m++) begin
      repeat (10) @(negedge clk);
      cfg_host_model_i.xfer({1'b0, ADDR_FORMAT, 5'h00, fmt_t[m]}, 1'b1, rd);
      repeat (10) @(negedge clk);
      run_mode(len_t[m], fmt_t[m][0] ? 0 : 1);
    end
    // Parallel mode: static pin levels
    par = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = 4'($urandom);
      cfg_host_model_i.set_static(r[0], r[1], r[2]);
      sdo_lvl = r[3];
      repeat (8) @(negedge clk);
      check("static_pins", 64'({pwr_dn, drv_half, term_en}), 64'({r[2], r[1], r[3]}));
    end
    // Power down through SDI: encodes give no frames
    cfg_host_model_i.set_static(1'b0, 1'b0, 1'b1);
    sdo_lvl = 1'b0;
    repeat (8) @(negedge clk);
    seen0 = frames_seen;
    repeat (3) encode_one(1'b0);
    check("pd_frames", 64'(frames_seen), 64'(seen0));
    // Chip select level picks two-lane, then one-lane
    cfg_host_model_i.set_static(1'b0, 1'b0, 1'b0);
    repeat (8) @(negedge clk);
    run_mode(16, 1);
    cfg_host_model_i.set_static(1'b1, 1'b0, 1'b0);
    repeat (8) @(negedge clk);
    run_mode(16, 0);
    summarize();
  end
endmodule : testbench
